// >>> logic/tbd_core.sv
// per-thread breakpoint, single-step and code-flush control with axi4-lite registers
// assumes one clock, synchronous active-low reset, and an issue stage that obeys issue_stall
`timescale 1ns/1ns
module tbd_core
   import tbd_pkg::*;
(
   // clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // axi4-lite slave
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   output logic [1:0]               s_axi_bresp,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   input  wire logic [7:0]          s_axi_araddr,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   // thread dispatch
   input  wire tbd_dispatch_t       dispatch,
   // issue stage
   input  wire tbd_instr_t          instr,
   output logic                     issue_ok,
   output logic                     issue_stall,
   // control transfer
   output logic                     redirect_ff,
   output logic [ADDR_W-1:0]        redirect_addr_ff,
   output logic                     prefetch_flush_ff,
   output logic                     cache_flush_ff,
   // interrupt
   output logic                     irq
);
   // --------------------------------------------------------------
   // register storage
   // --------------------------------------------------------------
   logic [NUM_BP-1:0][ADDR_W-1:0] bp_addr_ff;
   logic [NUM_BP-1:0]             bp_addr_vld_ff;
   logic [OPC_W-1:0]              bp_opc_ff;
   logic                          bp_opc_vld_ff;
   logic                          td_bp_en_ff;
   logic                          td_force_ff;
   logic                          suppress_ff;
   logic                          master_ff;
   logic                          thr_bp_en_ff;
   logic                          bp_stat_ff;
   logic [ADDR_W-1:0]             app_ptr_ff;
   logic [IRQ_W-1:0]              irq_stat_ff;
   logic [IRQ_W-1:0]              irq_mask_ff;
   logic                          marked;
   logic                          take_break;
   logic                          do_suppress;
   logic                          master_clr;

   // --------------------------------------------------------------
   // axi4-lite write channel
   // --------------------------------------------------------------
   logic                          aw_ff;
   logic                          w_ff;
   logic [7:0]                    awaddr_ff;
   logic [31:0]                   wdata_ff;
   logic                          wr_go;
   logic                          wr_hit;
   logic [31:0]                   wr_data;

   assign s_axi_awready = !aw_ff && !s_axi_bvalid;
   assign s_axi_wready  = !w_ff && !s_axi_bvalid;
   assign wr_go         = aw_ff && w_ff;
   assign wr_data       = wdata_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ff     <= 1'b0;
         w_ff      <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff  <= RST_ZERO;
      end else if (wr_go) begin
         aw_ff <= 1'b0;
         w_ff  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ff     <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ff     <= 1'b1;
            // partial writes keep only enabled lanes against zero
            wdata_ff <= s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                                       {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
         end
      end
   end

   always_comb begin
      unique case (awaddr_ff)
         OFS_BP_ADDR0, OFS_BP_ADDR1, OFS_BP_OPC, OFS_TD_CTL,
         OFS_CTRL_A, OFS_CTRL_B, OFS_FLUSH, OFS_IRQ_STAT, OFS_IRQ_MASK: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // --------------------------------------------------------------
   // axi4-lite read channel
   // --------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= RST_ZERO;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         s_axi_rdata  <= RST_ZERO;
         unique case (s_axi_araddr)
            OFS_BP_ADDR0: s_axi_rdata <= bp_addr_ff[0] | ADDR_W'(bp_addr_vld_ff[0]);
            OFS_BP_ADDR1: s_axi_rdata <= bp_addr_ff[1] | ADDR_W'(bp_addr_vld_ff[1]);
            OFS_BP_OPC:   s_axi_rdata <= {23'h0, bp_opc_vld_ff, 1'b0, bp_opc_ff};
            OFS_TD_CTL:   s_axi_rdata <= {30'h0, td_force_ff, td_bp_en_ff};
            OFS_CTRL_A:   s_axi_rdata <= {30'h0, master_ff, suppress_ff};
            OFS_CTRL_B:   s_axi_rdata <= {30'h0, bp_stat_ff, thr_bp_en_ff};
            OFS_FLUSH:    s_axi_rdata <= {31'h0, cache_flush_ff};
            OFS_IRQ_STAT: s_axi_rdata <= {29'h0, irq_stat_ff};
            OFS_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask_ff};
            default:      s_axi_rresp <= RESP_SLVERR;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // --------------------------------------------------------------
   // comparator registers and dispatcher debug controls
   // --------------------------------------------------------------
   // bit 0 of an address register is its valid; instructions are word aligned
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bp_addr_ff     <= '0;
         bp_addr_vld_ff <= '0;
         bp_opc_ff      <= '0;
         bp_opc_vld_ff  <= 1'b0;
         td_bp_en_ff    <= 1'b0;
         td_force_ff    <= 1'b0;
      end else if (wr_go) begin
         unique case (awaddr_ff)
            OFS_BP_ADDR0: begin
               bp_addr_ff[0]     <= {wr_data[ADDR_W-1:1], 1'b0};
               bp_addr_vld_ff[0] <= wr_data[BIT_AV];
            end
            OFS_BP_ADDR1: begin
               bp_addr_ff[1]     <= {wr_data[ADDR_W-1:1], 1'b0};
               bp_addr_vld_ff[1] <= wr_data[BIT_AV];
            end
            OFS_BP_OPC: begin
               bp_opc_ff     <= wr_data[OPC_W-1:0];
               bp_opc_vld_ff <= wr_data[BIT_OPC_VALID];
            end
            OFS_TD_CTL: begin
               td_bp_en_ff <= wr_data[BIT_TD_BP_EN];
               td_force_ff <= wr_data[BIT_TD_FORCE];
            end
            default: ;
         endcase
      end
   end

   // --------------------------------------------------------------
   // breakpoint decision
   // --------------------------------------------------------------
   tbd_match u_match (
      .instr       (instr),
      .bp_addr     (bp_addr_ff),
      .bp_addr_vld (bp_addr_vld_ff),
      .bp_opc      (bp_opc_ff),
      .bp_opc_vld  (bp_opc_vld_ff),
      .marked      (marked)
   );

   // a pending step (status still set) counts as an indication too
   logic indicated;
   assign indicated   = instr.valid && !master_ff && (marked || bp_stat_ff);
   assign do_suppress = indicated && thr_bp_en_ff && suppress_ff;
   assign take_break  = indicated && thr_bp_en_ff && !suppress_ff;
   // the instruction is held off in the cycle the break is decided
   assign issue_stall = take_break || master_ff;
   assign issue_ok    = instr.valid && !issue_stall;
   assign master_clr  = wr_go && (awaddr_ff == OFS_CTRL_A) && !wr_data[BIT_A_MASTER];

   // --------------------------------------------------------------
   // thread control register a: suppress and master state
   // --------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         suppress_ff <= 1'b0;
         master_ff   <= 1'b0;
      end else begin
         if (take_break) begin
            master_ff <= 1'b1;
         end else if (wr_go && awaddr_ff == OFS_CTRL_A) begin
            master_ff <= wr_data[BIT_A_MASTER];
         end
         // hardware clear after one suppression beats a same-cycle write
         if (do_suppress) begin
            suppress_ff <= 1'b0;
         end else if (wr_go && awaddr_ff == OFS_CTRL_A) begin
            suppress_ff <= wr_data[BIT_A_SUPPRESS];
         end
      end
   end

   // --------------------------------------------------------------
   // thread control register b: enable and break status
   // --------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         thr_bp_en_ff <= 1'b0;
         bp_stat_ff   <= 1'b0;
      end else begin
         if (dispatch.valid) begin
            thr_bp_en_ff <= (td_bp_en_ff && dispatch.snapshot) || td_force_ff;
         end else if (wr_go && awaddr_ff == OFS_CTRL_B) begin
            thr_bp_en_ff <= wr_data[BIT_B_BP_EN];
         end
         if (take_break) begin
            bp_stat_ff <= 1'b1;
         end else if (dispatch.valid) begin
            bp_stat_ff <= 1'b0;
         end else if (wr_go && awaddr_ff == OFS_CTRL_B) begin
            bp_stat_ff <= wr_data[BIT_B_BP_STAT];
         end
      end
   end

   // --------------------------------------------------------------
   // control transfer and prefetch discard
   // --------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         redirect_ff       <= 1'b0;
         redirect_addr_ff  <= RST_ZERO;
         prefetch_flush_ff <= 1'b0;
         app_ptr_ff        <= RST_ZERO;
      end else begin
         redirect_ff       <= take_break || (master_clr && master_ff);
         prefetch_flush_ff <= take_break || (master_clr && master_ff);
         if (take_break) begin
            app_ptr_ff       <= instr.addr;
            redirect_addr_ff <= SRE_PTR_RST;
         end else if (master_clr && master_ff) begin
            redirect_addr_ff <= app_ptr_ff;
         end
      end
   end

   // cache flush is a one-cycle pulse per write of one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cache_flush_ff <= 1'b0;
      end else begin
         cache_flush_ff <= wr_go && (awaddr_ff == OFS_FLUSH) && wr_data[0];
      end
   end

   // --------------------------------------------------------------
   // interrupts
   // --------------------------------------------------------------
   logic [IRQ_W-1:0] irq_evt;
   logic [IRQ_W-1:0] irq_w1c;
   assign irq_evt = {cache_flush_ff, do_suppress, take_break};
   assign irq_w1c = (wr_go && awaddr_ff == OFS_IRQ_STAT) ? wr_data[IRQ_W-1:0] : '0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_ff <= '0;
         irq_mask_ff <= '0;
      end else begin
         irq_stat_ff <= (irq_stat_ff & ~irq_w1c) | irq_evt;
         if (wr_go && awaddr_ff == OFS_IRQ_MASK) begin
            irq_mask_ff <= wr_data[IRQ_W-1:0];
         end
      end
   end

   assign irq = |(irq_stat_ff & irq_mask_ff);

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   break_no_issue_a: assert property (@(posedge aclk) disable iff (!aresetn)
      take_break |-> !issue_ok) else $error("issued on a break");
   field_break_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (instr.valid && instr.instr_debug_field == DBG_BREAKPOINT && thr_bp_en_ff && !suppress_ff && !master_ff)
      |=> master_ff && bp_stat_ff) else $error("field mark missed");
   addr_break_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (instr.valid && bp_addr_vld_ff[0] && instr.addr == bp_addr_ff[0] && thr_bp_en_ff && !suppress_ff
       && !master_ff) |=> redirect_ff) else $error("address mark missed");
   opc_break_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (instr.valid && bp_opc_vld_ff && instr.opcode == bp_opc_ff && thr_bp_en_ff && !suppress_ff
       && !master_ff) |-> take_break) else $error("opcode mark missed");
   enable_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (!thr_bp_en_ff && !master_ff && !(wr_go && awaddr_ff == OFS_CTRL_A)) |=> !master_ff && !redirect_ff)
      else $error("break while disabled");
   dispatch_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
      dispatch.valid |=> thr_bp_en_ff == $past(td_force_ff || (td_bp_en_ff && dispatch.snapshot)))
      else $error("dispatch enable wrong");
   suppress_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
      do_suppress |-> !take_break ##1 !suppress_ff) else $error("suppress not single");
   step_again_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (do_suppress && bp_stat_ff) ##1 (instr.valid && !master_ff && !(wr_go && awaddr_ff == OFS_CTRL_A)
       && thr_bp_en_ff && bp_stat_ff) |-> take_break) else $error("no step break");
   flush_entry_a: assert property (@(posedge aclk) disable iff (!aresetn)
      take_break |=> prefetch_flush_ff && redirect_addr_ff == SRE_PTR_RST) else $error("entry flush missing");
   cache_flush_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_go && awaddr_ff == OFS_FLUSH && wr_data[0]) |=> cache_flush_ff) else $error("cache flush missing");
endmodule : tbd_core

// >>> logic/tbd_pkg.sv
// package for the thread breakpoint debug block
// assumes a single clock domain and an axi4-lite register master
package tbd_pkg;
   localparam int          ADDR_W          = 32;
   localparam int          OPC_W           = 7;
   localparam int          NUM_BP          = 2;
   // register byte offsets
   localparam logic [7:0]  OFS_BP_ADDR0    = 8'h00;
   localparam logic [7:0]  OFS_BP_ADDR1    = 8'h04;
   localparam logic [7:0]  OFS_BP_OPC      = 8'h08;
   localparam logic [7:0]  OFS_TD_CTL      = 8'h0c;
   localparam logic [7:0]  OFS_CTRL_A      = 8'h10;
   localparam logic [7:0]  OFS_CTRL_B      = 8'h14;
   localparam logic [7:0]  OFS_FLUSH       = 8'h18;
   localparam logic [7:0]  OFS_IRQ_STAT    = 8'h1c;
   localparam logic [7:0]  OFS_IRQ_MASK    = 8'h20;
   // field positions
   localparam int          BIT_TD_BP_EN    = 0;
   localparam int          BIT_TD_FORCE    = 1;
   localparam int          BIT_A_SUPPRESS  = 0;
   localparam int          BIT_A_MASTER    = 1;
   localparam int          BIT_B_BP_EN     = 0;
   localparam int          BIT_B_BP_STAT   = 1;
   localparam int          BIT_OPC_VALID   = 8;
   localparam int          BIT_AV          = 0;
   // interrupt status bits
   localparam int          IRQ_BREAK       = 0;
   localparam int          IRQ_SUPP        = 1;
   localparam int          IRQ_FLUSH       = 2;
   localparam int          IRQ_W           = 3;
   // reset values, bus response codes and other fixed constants
   localparam logic [31:0] RST_ZERO        = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY       = 2'b00;
   localparam logic [1:0]  RESP_SLVERR     = 2'b10;
   localparam logic [1:0]  DBG_BREAKPOINT  = 2'h1;
   localparam logic [31:0] SRE_PTR_RST     = 32'h0000_1000;

   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] addr;
      logic [OPC_W-1:0]  opcode;
      logic [1:0]        instr_debug_field;
   } tbd_instr_t;

   typedef struct packed {
      logic       valid;
      logic       snapshot;
   } tbd_dispatch_t;
endpackage : tbd_pkg

// >>> logic/tbd_match.sv
// breakpoint indication decoder for one candidate instruction
// assumes the comparators are loaded from registers in the same clock domain
`timescale 1ns/1ns
module tbd_match
   import tbd_pkg::*;
(
   // candidate instruction
   input  wire tbd_instr_t                      instr,
   // programmed comparators
   input  wire logic [NUM_BP-1:0][ADDR_W-1:0]   bp_addr,
   input  wire logic [NUM_BP-1:0]               bp_addr_vld,
   input  wire logic [OPC_W-1:0]                bp_opc,
   input  wire logic                            bp_opc_vld,
   // result
   output logic                                 marked
);
   logic [NUM_BP-1:0] addr_hit;

   genvar g;
   generate
      for (g = 0; g < NUM_BP; g++) begin : g_addr
         assign addr_hit[g] = bp_addr_vld[g] && (bp_addr[g] == instr.addr);
      end
   endgenerate

   assign marked = instr.valid &&
                   ((instr.instr_debug_field == DBG_BREAKPOINT) ||
                    (|addr_hit) ||
                    (bp_opc_vld && (instr.opcode == bp_opc)));
endmodule : tbd_match

// >>> sim/tbd_partner.sv
// far-side model: fetch unit and cache watching the block's control transfers
// assumes the bench drives instructions and dispatch, and reads these counters
`timescale 1ns/1ns
module tbd_partner
   import tbd_pkg::*;
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // control transfer from the block
   input  wire logic              redirect_ff,
   input  wire logic [ADDR_W-1:0] redirect_addr_ff,
   input  wire logic              prefetch_flush_ff,
   input  wire logic              cache_flush_ff,
   // observed state
   output int                     n_redir,
   output int                     n_pflush,
   output int                     n_cflush,
   output logic [ADDR_W-1:0]      last_tgt
);
   // ----------------------------------------
   // fetch restart tracking
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         n_redir  <= 0;
         n_pflush <= 0;
         n_cflush <= 0;
         last_tgt <= '0;
      end else begin
         if (redirect_ff) begin
            n_redir  <= n_redir + 1;
            last_tgt <= redirect_addr_ff; // fetch restarts at the new pointer
         end
         if (prefetch_flush_ff) begin
            n_pflush <= n_pflush + 1; // prefetched words are dropped
         end
         if (cache_flush_ff) begin
            n_cflush <= n_cflush + 1; // patched code is refetched from memory
         end
      end
   end
endmodule : tbd_partner

// >>> sim/tbd_core_tb.sv
// testbench for the breakpoint block: bus tasks, instruction driver, checks
// assumes tbd_core as the device and tbd_partner watching its control outputs
`timescale 1ns/1ns
module tbd_core_tb
   import tbd_pkg::*;
;
   logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0]        s_axi_awaddr, s_axi_araddr;
   logic [31:0]       s_axi_wdata, s_axi_rdata, rd_q;
   logic [3:0]        s_axi_wstrb;
   logic [1:0]        s_axi_bresp, s_axi_rresp, resp_q;
   tbd_dispatch_t     dispatch;
   tbd_instr_t        instr;
   logic              issue_ok, issue_stall, redirect_ff, prefetch_flush_ff, cache_flush_ff, irq;
   logic [ADDR_W-1:0] redirect_addr_ff, last_tgt;
   int                n_fail, checks_done, n_redir, n_pflush, n_cflush;

   tbd_core i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
      .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
      .s_axi_rresp, .dispatch, .instr, .issue_ok, .issue_stall, .redirect_ff, .redirect_addr_ff,
      .prefetch_flush_ff, .cache_flush_ff, .irq);
   tbd_partner i_far (.aclk, .aresetn, .redirect_ff, .redirect_addr_ff, .prefetch_flush_ff,
      .cache_flush_ff, .n_redir, .n_pflush, .n_cflush, .last_tgt);

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic close_out;
      if (n_fail == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t ns: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk

   task automatic hung;
      n_fail++;
      $display("unexpected at %0t ns: no answer", $time);
      close_out();
   endtask : hung

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 40);
      if (s_axi_bvalid !== 1'b1) hung();
      resp_q = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 40);
      if (s_axi_rvalid !== 1'b1) hung();
      rd_q = s_axi_rdata;
      resp_q = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      rd(a);
      chk(rd_q, exp);
   endtask : rdc

   // one candidate instruction; a break must stop it before issue
   task automatic ins(input logic [31:0] a, input logic [6:0] op, input logic [1:0] f, input logic brk);
      instr <= '{1'b1, a, op, f};
      @(negedge aclk);
      chk(issue_ok, !brk);
      chk(issue_stall, brk);
      @(posedge aclk);
      instr.valid <= 1'b0;
      @(negedge aclk);
      chk(redirect_ff, brk);
      if (brk) chk(redirect_addr_ff, SRE_PTR_RST);
      @(posedge aclk);
   endtask : ins

   // handler return: write control a, expect a refetch at the application pointer
   task automatic ret(input logic [31:0] ctl_a, input logic [31:0] tgt);
      int r0;
      int n;
      r0 = n_redir;
      n = 0;
      wr(OFS_CTRL_A, ctl_a);
      while (n_redir == r0 && n < 20) begin
         @(negedge aclk);
         n++;
      end
      if (n_redir == r0) hung();
      chk(last_tgt, tgt);
      chk(n_pflush, n_redir);
      @(posedge aclk);
   endtask : ret

   task automatic dsp(input logic snap);
      dispatch <= '{1'b1, snap};
      @(posedge aclk);
      dispatch <= '{1'b0, 1'b0};
      @(posedge aclk);
   endtask : dsp

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      int n;
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      instr = '0;
      dispatch = '0;
      n_fail = 0;
      checks_done = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(OFS_CTRL_B, 32'h0);
      rd(8'h24);
      chk(resp_q, RESP_SLVERR);
      wr(8'h24, 32'h0);
      chk(resp_q, RESP_SLVERR);
      for (int k = 0; k < 8; k++) begin
         wr(OFS_TD_CTL, {30'h0, k[1:0]});
         dsp(k[2]);
         rdc(OFS_CTRL_B, {31'h0, (k[0] & k[2]) | k[1]});
      end
      wr(OFS_TD_CTL, 32'h0);
      dsp(1'b1);
      ins(32'h100, 7'h11, DBG_BREAKPOINT, 1'b0);
      wr(OFS_TD_CTL, 32'h2);
      dsp(1'b0);
      ins(32'h104, 7'h11, 2'h2, 1'b0);
      ins(32'h100, 7'h11, DBG_BREAKPOINT, 1'b1);
      rdc(OFS_CTRL_A, 32'h2);
      rdc(OFS_CTRL_B, 32'h3);
      chk(irq, 1'b0);
      wr(OFS_IRQ_MASK, 32'h1);
      chk(resp_q, RESP_OKAY);
      chk(irq, 1'b1);
      ret(32'h1, 32'h100);
      ins(32'h100, 7'h11, DBG_BREAKPOINT, 1'b0);
      rdc(OFS_CTRL_A, 32'h0);
      ins(32'h104, 7'h12, 2'h0, 1'b1);
      rdc(OFS_IRQ_STAT, 32'h3);
      wr(OFS_IRQ_STAT, 32'h3);
      chk(irq, 1'b0);
      // back-to-back pair: the suppressed one issues, the very next one breaks
      ret(32'h1, 32'h104);
      instr <= '{1'b1, 32'h104, 7'h12, 2'h0};
      @(negedge aclk);
      chk(issue_ok, 1'b1);
      @(posedge aclk);
      instr <= '{1'b1, 32'h108, 7'h13, 2'h0};
      @(negedge aclk);
      chk(issue_stall, 1'b1);
      @(posedge aclk);
      instr.valid <= 1'b0;
      @(negedge aclk);
      chk(redirect_ff, 1'b1);
      @(posedge aclk);
      wr(OFS_CTRL_B, 32'h1);
      ret(32'h1, 32'h108);
      ins(32'h104, 7'h12, 2'h0, 1'b0);
      ins(32'h108, 7'h13, 2'h0, 1'b0);
      wr(OFS_CTRL_A, 32'h0);
      for (int j = 0; j < 2; j++) begin
         wr(j ? OFS_BP_ADDR1 : OFS_BP_ADDR0, 32'h201 + 8 * j);
         ins(32'h200 + 8 * j, 7'h14, 2'h0, 1'b1);
         wr(OFS_CTRL_B, 32'h1);
         ret(32'h0, 32'h200 + 8 * j);
      end
      wr(OFS_BP_OPC, 32'h12a);
      ins(32'h300, 7'h2a, 2'h0, 1'b1);
      wr(OFS_CTRL_B, 32'h1);
      ret(32'h0, 32'h300);
      ins(32'h304, 7'h2b, 2'h0, 1'b0);
      wr(OFS_FLUSH, 32'h1);
      n = 0;
      while (n_cflush == 0 && n < 20) begin
         @(negedge aclk);
         n++;
      end
      chk(n_cflush, 32'h1);
      close_out();
   end
endmodule : tbd_core_tb
